// file: src/ccl_pkg.sv
/*
  Package for the calendar counter capture/compare and lock register block.
  Assumes an AXI4-Lite master with 32-bit data and a single core clock.
*/
package ccl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CCL_OFF_PWR_OFF = 8'h34;
  localparam logic [7:0] CCL_OFF_LOCK = 8'h38;
  localparam logic [7:0] CCL_OFF_WAKE = 8'h3c;
  localparam logic [7:0] CCL_OFF_CH_CTRL = 8'h40;
  localparam logic [7:0] CCL_OFF_CH_VALUE = 8'h44;
  localparam logic [7:0] CCL_OFF_CH_TIME = 8'h48;
  localparam logic [7:0] CCL_OFF_CH_DATE = 8'h4c;
  localparam logic [7:0] CCL_OFF_SYNC_BUSY = 8'h50;
  localparam logic [7:0] CCL_OFF_CMD = 8'h54;
  localparam logic [7:0] CCL_OFF_IRQ_FLAG = 8'h58;
  localparam logic [7:0] CCL_OFF_IRQ_CLEAR = 8'h5c;
  localparam logic [7:0] CCL_OFF_IRQ_ENABLE = 8'h60;
  localparam logic [7:0] CCL_OFF_STATUS = 8'h64;
  localparam logic [7:0] CCL_OFF_COUNTER = 8'h68;

  // ****************************************************************
  // Fields and values
  // ****************************************************************
  localparam logic [15:0] CCL_UNLOCK_KEY = 16'haee8;
  localparam int CCL_SYNC_BUSY_BIT = 5;
  localparam int CCL_IRQ_CH_BIT = 1;
  localparam logic [3:0] CCL_NUM_EVENTS = 4'hc;
  localparam logic [1:0] CCL_MODE_OFF = 2'h0;
  localparam logic [1:0] CCL_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] CCL_MODE_COMPARE = 2'h2;
  localparam logic [1:0] CCL_EDGE_RISE = 2'h0;
  localparam logic [1:0] CCL_EDGE_FALL = 2'h1;
  localparam logic [1:0] CCL_EDGE_BOTH = 2'h2;
  localparam logic [1:0] CCL_ACT_PULSE = 2'h0;
  localparam logic [1:0] CCL_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] CCL_ACT_CLEAR = 2'h2;
  localparam logic [31:0] CCL_CH_CTRL_MASK = 32'h0003fbff;
  localparam logic [31:0] CCL_TIME_MASK = 32'h003f7f7f;
  localparam logic [31:0] CCL_DATE_MASK = 32'h00001f3f;
  localparam logic [31:0] CCL_VALUE_RESET = 32'h00000000;
  localparam logic [1:0] CCL_SYNC_CYCLES = 2'h3;
  localparam logic [1:0] CCL_RESP_OKAY = 2'h0;
  localparam logic [1:0] CCL_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } ccl_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } ccl_axi_rsp_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic w_held;
    logic [1:0] bresp;
    logic bvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic pwr_off;
    logic locked;
    logic wake_en;
    logic [31:0] ch_ctrl;
    logic [31:0] ch_value;
    logic [31:0] ch_time;
    logic [31:0] ch_date;
    logic [1:0] sync_cnt;
    logic [31:0] status;
    logic irq_flag;
    logic irq_en;
    logic [11:0] ev_s1;
    logic [11:0] ev_s2;
    logic ev_prev;
    logic ch_out;
    logic wake_req;
  } ccl_state_t;

endpackage

// file: src/ccl_regs.sv
/*
  Calendar counter lock, retention power-off, wake-up and one capture/compare channel.
  Assumes the counter, time and date arrive already in the core clock domain,
  and that the event channels are asynchronous and need synchronising here.
*/
`timescale 1ns/1ps
// Overview of operation
// - Sync busy bit 5 stays high while a command write crosses domains.
// - Retention power-off bit is sticky; nothing but reset restores power.
// - Any non-key lock write blocks writes to protected registers.
// - Writing key 0xAEE8 unlocks all protected registers.
// - Lock register reads bit 0 as one when locked, zero when unlocked.
// - Wake-up enable one allows deep-sleep wake-up requests; zero suppresses them.
// - Selector values 0 to 11 pick the event channel of that number.
// - Edge field: 0 rising, 1 falling, 2 both, 3 level passes unchanged.
// - Match action: 0 one-cycle pulse, 1 toggle, 2 clear, 3 set.
// - Mode 0 switches the channel off; mode 1 means input capture.
// - Value register resets to zero; in calendar mode ignores writes, reads zero.
// - Command bit 0 clears the status register after synchronisation.
// - Write one clears channel flag; optional read-clear returns then clears flags.
module ccl_regs (
  input wire logic core_clk,
  input wire logic reset,
  // Register bus.
  input wire ccl_pkg::ccl_axi_req_t axi_req,
  output ccl_pkg::ccl_axi_rsp_t axi_rsp,
  // Calendar counter side.
  input wire logic [31:0] main_counter,
  input wire logic [31:0] time_bcd,
  input wire logic [31:0] date_bcd,
  input wire logic calendar_mode,
  input wire logic read_clear_en,
  input wire logic [11:0] event_in,
  // Outputs.
  output logic ret_ram_power_off,
  output logic deep_sleep_wakeup,
  output logic channel_out,
  output logic irq
);
  import ccl_pkg::*;

  ccl_state_t state_reg;
  ccl_state_t state_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_fire;
  logic rd_fire;
  logic [3:0] ev_sel;
  logic ev_sig;
  logic edge_hit;
  logic match_hit;
  logic [1:0] mode;
  logic [1:0] edge_sel;
  logic [1:0] action;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  always_comb begin
    mode = state_reg.ch_ctrl[1:0];
    action = state_reg.ch_ctrl[3:2];
    edge_sel = state_reg.ch_ctrl[5:4];
    ev_sel = state_reg.ch_ctrl[9:6];
    // Selectors above eleven point at no channel and read as a quiet input.
    ev_sig = (ev_sel < CCL_NUM_EVENTS) ? state_reg.ev_s2[ev_sel] : 1'b0;
    unique case (edge_sel)
      CCL_EDGE_RISE: edge_hit = ev_sig & ~state_reg.ev_prev;
      CCL_EDGE_FALL: edge_hit = ~ev_sig & state_reg.ev_prev;
      CCL_EDGE_BOTH: edge_hit = ev_sig ^ state_reg.ev_prev;
      default: edge_hit = ev_sig;
    endcase
    match_hit = (mode == CCL_MODE_COMPARE) && (main_counter == state_reg.ch_value);
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_fire = axi_req.arvalid && !state_reg.rvalid;

  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    unique case (axi_req.araddr)
      CCL_OFF_PWR_OFF: rd_val = {31'h00000000, state_reg.pwr_off};
      CCL_OFF_LOCK: rd_val = {31'h00000000, state_reg.locked};
      CCL_OFF_WAKE: rd_val = {31'h00000000, state_reg.wake_en};
      CCL_OFF_CH_CTRL: rd_val = state_reg.ch_ctrl;
      CCL_OFF_CH_VALUE: rd_val = calendar_mode ? 32'h00000000 : state_reg.ch_value;
      CCL_OFF_CH_TIME: rd_val = calendar_mode ? state_reg.ch_time : 32'h00000000;
      CCL_OFF_CH_DATE: rd_val = calendar_mode ? state_reg.ch_date : 32'h00000000;
      CCL_OFF_SYNC_BUSY: rd_val = {26'h0000000, (state_reg.sync_cnt != 2'h0), 5'h00};
      CCL_OFF_CMD: rd_val = 32'h00000000;
      CCL_OFF_IRQ_FLAG: rd_val = {30'h00000000, state_reg.irq_flag, 1'b0};
      CCL_OFF_IRQ_CLEAR: rd_val = read_clear_en ? {30'h00000000, state_reg.irq_flag, 1'b0} : 32'h00000000;
      CCL_OFF_IRQ_ENABLE: rd_val = {30'h00000000, state_reg.irq_en, 1'b0};
      CCL_OFF_STATUS: rd_val = state_reg.status;
      CCL_OFF_COUNTER: rd_val = main_counter;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (state_reg.awaddr)
      CCL_OFF_PWR_OFF, CCL_OFF_LOCK, CCL_OFF_WAKE, CCL_OFF_CH_CTRL, CCL_OFF_CH_VALUE,
      CCL_OFF_CH_TIME, CCL_OFF_CH_DATE, CCL_OFF_SYNC_BUSY, CCL_OFF_CMD, CCL_OFF_IRQ_FLAG,
      CCL_OFF_IRQ_CLEAR, CCL_OFF_IRQ_ENABLE, CCL_OFF_STATUS, CCL_OFF_COUNTER: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] wd;
    logic prot_ok;
    logic flag_set;
    logic flag_clr;
    wd = merge_strb(32'h00000000, state_reg.wdata, 4'hf);
    prot_ok = wr_fire && !state_reg.locked;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    state_next = state_reg;
    // Write address and data may arrive in either order; each is held until both are in.
    if (axi_req.awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.wdata = merge_strb(32'h00000000, axi_req.wdata, axi_req.wstrb);
    end
    if (state_reg.bvalid && axi_req.bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && axi_req.rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.ev_s1 = event_in;
    state_next.ev_s2 = state_reg.ev_s1;
    state_next.ev_prev = ev_sig;
    if (state_reg.sync_cnt != 2'h0) begin
      state_next.sync_cnt = state_reg.sync_cnt - 2'h1;
      if (state_reg.sync_cnt == 2'h1) begin
        state_next.status = 32'h00000000;
      end
    end
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wr_ok ? CCL_RESP_OKAY : CCL_RESP_SLVERR;
      unique case (state_reg.awaddr)
        CCL_OFF_LOCK: state_next.locked = (wd[15:0] != CCL_UNLOCK_KEY);
        CCL_OFF_PWR_OFF: begin
          // Once removed, power is restored only by reset.
          if (prot_ok && wd[0]) begin
            state_next.pwr_off = 1'b1;
          end
        end
        CCL_OFF_WAKE: begin
          if (prot_ok) begin
            state_next.wake_en = wd[0];
          end
        end
        CCL_OFF_CH_CTRL: begin
          if (prot_ok) begin
            state_next.ch_ctrl = wd & CCL_CH_CTRL_MASK;
          end
        end
        CCL_OFF_CH_VALUE: begin
          if (prot_ok && !calendar_mode) begin
            state_next.ch_value = wd;
          end
        end
        CCL_OFF_CH_TIME: begin
          if (prot_ok && calendar_mode) begin
            state_next.ch_time = wd & CCL_TIME_MASK;
          end
        end
        CCL_OFF_CH_DATE: begin
          if (prot_ok && calendar_mode) begin
            state_next.ch_date = wd & CCL_DATE_MASK;
          end
        end
        CCL_OFF_CMD: begin
          if (wd[0]) begin
            state_next.sync_cnt = CCL_SYNC_CYCLES;
          end
        end
        CCL_OFF_IRQ_CLEAR: flag_clr = wd[CCL_IRQ_CH_BIT];
        CCL_OFF_IRQ_ENABLE: begin
          if (prot_ok) begin
            state_next.irq_en = wd[CCL_IRQ_CH_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_val;
      state_next.rresp = rd_ok ? CCL_RESP_OKAY : CCL_RESP_SLVERR;
      if (read_clear_en && axi_req.araddr == CCL_OFF_IRQ_CLEAR) begin
        flag_clr = 1'b1;
      end
    end
    // Channel behaviour; mode zero leaves the channel idle.
    state_next.ch_out = (action == CCL_ACT_PULSE) ? 1'b0 : state_reg.ch_out;
    if (mode == CCL_MODE_CAPTURE && edge_hit) begin
      flag_set = 1'b1;
      if (calendar_mode) begin
        state_next.ch_time = time_bcd & CCL_TIME_MASK;
        state_next.ch_date = date_bcd & CCL_DATE_MASK;
      end else begin
        state_next.ch_value = main_counter;
      end
    end
    if (match_hit) begin
      flag_set = 1'b1;
      unique case (action)
        CCL_ACT_PULSE: state_next.ch_out = 1'b1;
        CCL_ACT_TOGGLE: state_next.ch_out = ~state_reg.ch_out;
        CCL_ACT_CLEAR: state_next.ch_out = 1'b0;
        default: state_next.ch_out = 1'b1;
      endcase
    end
    // A new event beats a clear in the same cycle so none is lost.
    state_next.irq_flag = flag_set | (state_reg.irq_flag & ~flag_clr);
    state_next.wake_req = state_reg.wake_en & flag_set;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign axi_rsp.awready = !state_reg.aw_held;
  assign axi_rsp.wready = !state_reg.w_held;
  assign axi_rsp.bvalid = state_reg.bvalid;
  assign axi_rsp.bresp = state_reg.bresp;
  assign axi_rsp.arready = !state_reg.rvalid;
  assign axi_rsp.rvalid = state_reg.rvalid;
  assign axi_rsp.rdata = state_reg.rdata;
  assign axi_rsp.rresp = state_reg.rresp;
  assign ret_ram_power_off = state_reg.pwr_off;
  assign deep_sleep_wakeup = state_reg.wake_req;
  assign channel_out = state_reg.ch_out;
  assign irq = state_reg.irq_flag & state_reg.irq_en;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_pwr_stays_off: assert property (@(posedge core_clk) disable iff (reset)
    state_reg.pwr_off |=> state_reg.pwr_off) else $error("retention power came back");
  a_key_unlocks: assert property (@(posedge core_clk) disable iff (reset)
    (wr_fire && state_reg.awaddr == CCL_OFF_LOCK && state_reg.wdata[15:0] == CCL_UNLOCK_KEY)
    |=> !state_reg.locked) else $error("unlock key did not unlock");
  a_lock_blocks_ctrl: assert property (@(posedge core_clk) disable iff (reset)
    (wr_fire && state_reg.locked && state_reg.awaddr == CCL_OFF_CH_CTRL)
    |=> $stable(state_reg.ch_ctrl)) else $error("locked control register changed");
  a_busy_after_cmd: assert property (@(posedge core_clk) disable iff (reset)
    (wr_fire && state_reg.awaddr == CCL_OFF_CMD && state_reg.wdata[0])
    |=> (state_reg.sync_cnt != 2'h0) [*3] ##1 (state_reg.sync_cnt == 2'h0)) else $error("busy length wrong");
  a_status_wiped: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg.sync_cnt == 2'h1) |=> (state_reg.status == 32'h00000000)) else $error("status not wiped");
  a_match_flags: assert property (@(posedge core_clk) disable iff (reset)
    match_hit |=> state_reg.irq_flag) else $error("match did not set flag");
  a_pulse_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
    (match_hit && action == CCL_ACT_PULSE) ##1 !match_hit && action == CCL_ACT_PULSE
    |-> state_reg.ch_out ##1 !state_reg.ch_out) else $error("pulse width wrong");
  a_capture_loads: assert property (@(posedge core_clk) disable iff (reset)
    (mode == CCL_MODE_CAPTURE && edge_hit && !calendar_mode)
    |=> state_reg.ch_value == $past(main_counter) && state_reg.irq_flag) else $error("capture missed");
  a_off_no_flag: assert property (@(posedge core_clk) disable iff (reset)
    (mode == CCL_MODE_OFF && !state_reg.irq_flag && !(wr_fire && state_reg.awaddr == CCL_OFF_CH_CTRL))
    |=> !state_reg.irq_flag) else $error("idle channel raised flag");
  a_value_reads_zero: assert property (@(posedge core_clk) disable iff (reset)
    (rd_fire && calendar_mode && axi_req.araddr == CCL_OFF_CH_VALUE)
    |=> state_reg.rdata == 32'h00000000) else $error("value read not zero");

endmodule // ccl_regs

// file: verif/ccl_regs_test.sv
/*
  Self-checking bench for ccl_regs: AXI4-Lite read and write tasks and directed tests.
  Assumes the block answers every bus request within a few dozen core clock cycles.
*/
`timescale 1ns/1ps
module ccl_regs_test;
  import ccl_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  ccl_axi_req_t req = '0;
  ccl_axi_rsp_t rsp;
  logic [31:0] main_counter = 32'h0;
  logic calendar_mode = 1'b0;
  logic read_clear_en = 1'b0;
  logic [11:0] event_in = 12'h0;
  logic ret_ram_power_off;
  logic deep_sleep_wakeup;
  logic channel_out;
  logic irq;
  int bad_count = 0;
  int total_checks = 0;
  int wake_cnt = 0;
  int w0;
  int n;
  logic [31:0] rd_v;
  logic [1:0] rs;
  // Edge table: mode, event level, counter, expected captured value.
  logic [1:0] e_tab [8] = '{CCL_EDGE_FALL, CCL_EDGE_FALL, CCL_EDGE_BOTH, CCL_EDGE_BOTH, 2'h3, 2'h3, 2'h3, CCL_EDGE_RISE};
  logic ev_tab [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [31:0] cn_tab [8] = '{32'h200, 32'h200, 32'h300, 32'h301, 32'h400, 32'h401, 32'h402, 32'h500};
  // In level mode the input keeps capturing until the synchronised low arrives, so the last counter value wins.
  logic [31:0] ex_tab [8] = '{32'h10b, 32'h200, 32'h300, 32'h301, 32'h400, 32'h401, 32'h402, 32'h500};
  logic [1:0] act_tab [4] = '{2'h3, CCL_ACT_CLEAR, CCL_ACT_TOGGLE, CCL_ACT_TOGGLE};

  always #2 core_clk = ~core_clk;
  // The wake-up output is a one-cycle pulse, so it is counted rather than sampled.
  always @(posedge core_clk) if (deep_sleep_wakeup === 1'b1) wake_cnt <= wake_cnt + 1;

  ccl_regs ccl_regs_i (.core_clk(core_clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
    .main_counter(main_counter), .time_bcd(32'h00123456), .date_bcd(32'h00000a15),
    .calendar_mode(calendar_mode), .read_clear_en(read_clear_en), .event_in(event_in),
    .ret_ram_power_off(ret_ram_power_off), .deep_sleep_wakeup(deep_sleep_wakeup),
    .channel_out(channel_out), .irq(irq));

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    bad_count++;
    $display("BAD %s expected answer seen timeout", what);
    final_report();
  endtask

  // Every bus task opens with a clock edge so that no request field is assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int k;
    k = 0;
    @(posedge core_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      k++;
      if (k > 50) hang("write");
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int k;
    k = 0;
    @(posedge core_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      k++;
      if (k > 50) hang("read");
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, exp, d);
  endtask

  // Generous settle time covers the two synchroniser flops and the edge compare.
  task automatic set_ev(input int i, input logic v);
    @(posedge core_clk);
    event_in[i] <= v;
    repeat (8) @(posedge core_clk);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rchk("power off reset", CCL_OFF_PWR_OFF, 32'h0);
    rchk("lock reset", CCL_OFF_LOCK, 32'h0);
    rchk("wake reset", CCL_OFF_WAKE, 32'h0);
    rchk("value reset", CCL_OFF_CH_VALUE, CCL_VALUE_RESET);
    rd(8'h70, rd_v, rs);
    chk("unmapped resp", 32'(CCL_RESP_SLVERR), 32'(rs));
    $display("test reset values done");
    wr(CCL_OFF_LOCK, 32'h0, rs);
    rchk("lock set", CCL_OFF_LOCK, 32'h1);
    wr(CCL_OFF_CH_CTRL, 32'h1, rs);
    rchk("ctrl locked", CCL_OFF_CH_CTRL, 32'h0);
    wr(CCL_OFF_PWR_OFF, 32'h1, rs);
    chk("power off locked", 32'h0, 32'(ret_ram_power_off));
    wr(CCL_OFF_LOCK, 32'h0000aee7, rs);
    rchk("lock near key", CCL_OFF_LOCK, 32'h1);
    wr(CCL_OFF_LOCK, {16'h0, CCL_UNLOCK_KEY}, rs);
    rchk("lock cleared", CCL_OFF_LOCK, 32'h0);
    wr(CCL_OFF_PWR_OFF, 32'h1, rs);
    wr(CCL_OFF_PWR_OFF, 32'h0, rs);
    chk("power off sticky", 32'h1, 32'(ret_ram_power_off));
    rchk("power off reads", CCL_OFF_PWR_OFF, 32'h1);
    $display("test lock and power off done");
    wr(CCL_OFF_CMD, 32'h1, rs);
    rd(CCL_OFF_SYNC_BUSY, rd_v, rs);
    chk("sync busy set", 32'h1, 32'(rd_v[CCL_SYNC_BUSY_BIT]));
    n = 0;
    while (rd_v[CCL_SYNC_BUSY_BIT] !== 1'b0 && n < 20) begin
      rd(CCL_OFF_SYNC_BUSY, rd_v, rs);
      n++;
    end
    chk("sync busy clear", 32'h0, 32'(rd_v[CCL_SYNC_BUSY_BIT]));
    rchk("status wiped", CCL_OFF_STATUS, 32'h0);
    $display("test command sync done");
    wr(CCL_OFF_IRQ_ENABLE, 32'h2, rs);
    for (int i = 0; i < 12; i++) begin
      wr(CCL_OFF_CH_CTRL, (32'(i) << 6) | 32'(CCL_MODE_CAPTURE), rs);
      main_counter <= 32'h100 + 32'(i);
      set_ev(i, 1'b1);
      set_ev(i, 1'b0);
      rchk("capture select", CCL_OFF_CH_VALUE, 32'h100 + 32'(i));
      chk("irq on capture", 32'h1, 32'(irq));
      wr(CCL_OFF_IRQ_CLEAR, 32'h2, rs);
      chk("irq cleared", 32'h0, 32'(irq));
    end
    for (int s = 0; s < 8; s++) begin
      wr(CCL_OFF_CH_CTRL, (32'h2 << 6) | (32'(e_tab[s]) << 4) | 32'(CCL_MODE_CAPTURE), rs);
      main_counter <= cn_tab[s];
      set_ev(2, ev_tab[s]);
      rchk("edge select", CCL_OFF_CH_VALUE, ex_tab[s]);
    end
    $display("test capture done");
    wr(CCL_OFF_WAKE, 32'h1, rs);
    set_ev(2, 1'b0);
    w0 = wake_cnt;
    set_ev(2, 1'b1);
    chk("wake pulses", 32'h1, 32'(wake_cnt - w0));
    wr(CCL_OFF_IRQ_ENABLE, 32'h0, rs);
    chk("irq masked", 32'h0, 32'(irq));
    rchk("flag pending", CCL_OFF_IRQ_FLAG, 32'h2);
    read_clear_en <= 1'b1;
    rchk("read clear value", CCL_OFF_IRQ_CLEAR, 32'h2);
    rchk("read clear flag", CCL_OFF_IRQ_FLAG, 32'h0);
    read_clear_en <= 1'b0;
    wr(CCL_OFF_WAKE, 32'h0, rs);
    set_ev(2, 1'b0);
    w0 = wake_cnt;
    set_ev(2, 1'b1);
    chk("wake suppressed", 32'h0, 32'(wake_cnt - w0));
    wr(CCL_OFF_IRQ_CLEAR, 32'h2, rs);
    $display("test wake and irq done");
    wr(CCL_OFF_CH_VALUE, 32'h777, rs);
    for (int s = 0; s < 4; s++) begin
      wr(CCL_OFF_CH_CTRL, (32'(act_tab[s]) << 2) | 32'(CCL_MODE_COMPARE), rs);
      main_counter <= 32'h777;
      @(posedge core_clk);
      main_counter <= 32'h778;
      repeat (4) @(posedge core_clk);
      chk("match output", 32'(s % 2 == 0), 32'(channel_out));
    end
    // Pulse action: high for exactly the one cycle after the match.
    wr(CCL_OFF_CH_CTRL, 32'(CCL_MODE_COMPARE), rs);
    main_counter <= 32'h777;
    @(posedge core_clk);
    main_counter <= 32'h778;
    @(posedge core_clk);
    chk("pulse high", 32'h1, 32'(channel_out));
    @(posedge core_clk);
    chk("pulse low", 32'h0, 32'(channel_out));
    rchk("match flag", CCL_OFF_IRQ_FLAG, 32'h2);
    wr(CCL_OFF_IRQ_CLEAR, 32'h2, rs);
    wr(CCL_OFF_CH_CTRL, (32'h2 << 6) | 32'(CCL_MODE_OFF), rs);
    set_ev(2, 1'b0);
    set_ev(2, 1'b1);
    rchk("channel off", CCL_OFF_IRQ_FLAG, 32'h0);
    calendar_mode <= 1'b1;
    wr(CCL_OFF_CH_VALUE, 32'h55, rs);
    rchk("value calendar", CCL_OFF_CH_VALUE, 32'h0);
    calendar_mode <= 1'b0;
    rchk("value write ignored", CCL_OFF_CH_VALUE, 32'h777);
    $display("test compare and modes done");
    final_report();
  end
endmodule // ccl_regs_test
